// ---- src/ddc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module ddc_top import ddc_pkg::*; (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Converter samples and sync pin
    input wire logic [ADC_W-1:0] ADC_FIRST,
    input wire logic [ADC_W-1:0] ADC_SECOND,
    input wire logic SYNC,
    // Results to the output formatter
    output logic [INT_W-1:0] FIRST_I,
    output logic [INT_W-1:0] FIRST_Q,
    output logic [INT_W-1:0] SECOND_I,
    output logic [INT_W-1:0] SECOND_Q,
    output logic OUT_VALID
);
    logic [31:0] ctrl_reg;
    logic [NCO_W-1:0] nco_reg;
    logic [NCO_W-1:0] act_reg;
    logic [NCO_W-1:0] phase_reg;
    logic pend_reg;
    logic restart_d_reg;
    logic sync_m_reg;
    logic sync_s_reg;
    logic sync_d_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [INT_W-1:0] first_i_reg;
    logic [INT_W-1:0] first_q_reg;
    logic [INT_W-1:0] second_i_reg;
    logic [INT_W-1:0] second_q_reg;
    logic out_vld_reg;

    logic acc_ph;
    logic take;
    logic hit_ctrl;
    logic hit_nco;
    logic hit_stat;
    logic hit_act;
    logic bad;
    logic wr_ctrl;
    logic wr_nco;
    logic apply;
    logic swap;
    logic [1:0] res;
    logic [INT_W-1:0] mask;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;
    logic signed [LUT_W-1:0] sin_raw;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode, one wait state per transfer
    assign acc_ph = PSEL && PENABLE;
    assign take = acc_ph && pready_reg;
    assign hit_ctrl = PADDR == OFS_CTRL;
    assign hit_nco = PADDR == OFS_NCO;
    assign hit_stat = PADDR == OFS_STAT;
    assign hit_act = PADDR == OFS_NCO_ACT;
    assign bad = !(hit_ctrl || hit_nco || hit_stat || hit_act) ||
                 (PWRITE && (hit_stat || hit_act));
    assign wr_ctrl = take && PWRITE && hit_ctrl;
    assign wr_nco = take && PWRITE && hit_nco;
    assign stat_word = {30'h0, pend_reg, ctrl_reg[B_EN]};
    assign rd_mux = hit_ctrl ? ctrl_reg :
                    hit_nco ? nco_reg :
                    hit_stat ? stat_word :
                    hit_act ? act_reg : 32'h0000_0000;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= acc_ph && !pready_reg;
            pslverr_reg <= acc_ph && !pready_reg && bad;
            prdata_reg <= (acc_ph && !pready_reg && !PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ctrl_reg <= CTRL_RST;
            nco_reg <= NCO_RST;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= PWDATA & CTRL_MASK;
            if (wr_nco)
                nco_reg <= PWDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator: restart toggle or sync rise loads the new word
    // deferred frequency
    assign apply = (ctrl_reg[B_RESTART] != restart_d_reg) || (sync_s_reg && !sync_d_reg);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sync_m_reg <= 1'b0;
            sync_s_reg <= 1'b0;
            sync_d_reg <= 1'b0;
            restart_d_reg <= 1'b0;
        end else begin
            sync_m_reg <= SYNC;
            sync_s_reg <= sync_m_reg;
            sync_d_reg <= sync_s_reg;
            restart_d_reg <= ctrl_reg[B_RESTART];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            act_reg <= NCO_RST;
            phase_reg <= NCO_RST;
            pend_reg <= 1'b0;
        end else begin
            act_reg <= apply ? nco_reg : act_reg;
            phase_reg <= apply ? NCO_RST : phase_reg + act_reg;
            pend_reg <= wr_nco || (pend_reg && !apply);
        end
    end

    // Quadrature is cosine a quarter turn back; inverting gives the conjugate
    assign sin_raw = cos_lut(phase_reg[NCO_W-1:NCO_W-4] - 4'h4);

    ////////////////////////////////////////////////////////////////////////////////
    // Two filter channels behind the swap mux
    ddc_ch_if ch [2] ();
    assign swap = ctrl_reg[B_SWAP];

    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign ch[g].en = ctrl_reg[B_EN];
        assign ch[g].real_mode = ctrl_reg[B_REAL];
        assign ch[g].gain6 = ctrl_reg[B_GAIN6];
        assign ch[g].gain3 = ctrl_reg[B_GAIN3];
        assign ch[g].dec_log2 = ctrl_reg[F_DEC_LO+:3];
        assign ch[g].cos_v = cos_lut(phase_reg[NCO_W-1:NCO_W-4]);
        assign ch[g].sin_v = ctrl_reg[B_INV] ? -sin_raw : sin_raw;
        assign ch[g].sample = ((g == 1) != swap) ? ADC_SECOND : ADC_FIRST;
        ddc_chan u_chan (
            .clk(CLK),
            .rst_b(RST_B),
            .ch(ch[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output truncation
    assign res = ctrl_reg[F_RES_LO+:2];
    assign mask = res_mask(res);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            first_i_reg <= '0;
            first_q_reg <= '0;
            second_i_reg <= '0;
            second_q_reg <= '0;
            out_vld_reg <= 1'b0;
        end else begin
            out_vld_reg <= ch[0].out_vld;
            if (ch[0].out_vld) begin
                first_i_reg <= ch[0].out_i & mask;
                first_q_reg <= ch[0].out_q & mask;
                second_i_reg <= ch[1].out_i & mask;
                second_q_reg <= ch[1].out_q & mask;
            end
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign FIRST_I = first_i_reg;
    assign FIRST_Q = first_q_reg;
    assign SECOND_I = second_i_reg;
    assign SECOND_Q = second_q_reg;
    assign OUT_VALID = out_vld_reg;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    property p_swap;
        swap |-> ch[0].sample == ADC_SECOND && ch[1].sample == ADC_FIRST;
    endproperty
    a_swap: assert property (p_swap) else $error("swap routing wrong");

    property p_ctrl;
        wr_ctrl |=> ctrl_reg == ($past(PWDATA) & CTRL_MASK);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control write lost");

    property p_apply;
        apply |=> act_reg == $past(nco_reg) && phase_reg == NCO_RST;
    endproperty
    a_apply: assert property (p_apply) else $error("frequency not applied");

    property p_hold;
        !apply |=> $stable(act_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("frequency changed early");

    property p_phase;
        !apply |=> phase_reg == $past(phase_reg) + $past(act_reg);
    endproperty
    a_phase: assert property (p_phase) else $error("phase step wrong");

    property p_lane;
        ch[1].out_vld |=> SECOND_I == ($past(ch[1].out_i) & res_mask($past(res)));
    endproperty
    a_lane: assert property (p_lane) else $error("second lane mismatch");

    property p_trunc;
        ch[0].out_vld |=> (FIRST_Q & ~res_mask($past(res))) == 20'h00000;
    endproperty
    a_trunc: assert property (p_trunc) else $error("low bits not cut");

    property p_off;
        !ctrl_reg[B_EN] |-> ##2 OUT_VALID;
    endproperty
    a_off: assert property (p_off) else $error("disabled path not full rate");

    property p_ready;
        acc_ph && !PREADY |=> PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("bus answer late");

    c_swap: cover property (swap && ctrl_reg[B_EN] && OUT_VALID);
    c_restart: cover property (ctrl_reg[B_RESTART] != restart_d_reg);
    c_sync: cover property (sync_s_reg && !sync_d_reg);
endmodule // ddc_top
`default_nettype wire

// ---- include/ddc_pkg.sv ----
// Functional notes
// - Converter runs only when software enables it
// - Complex mode: 32-bit oscillator, decimate 2..32
// - Real mode bypasses mixer, filter is lowpass
// - Filter arithmetic results carry 20 bits
// - Results truncated to selected output resolution
// - Swap mux crosses converter channels into filters
// - Swap set only by software register writes
// - Output lanes carry filter channels A and B
// - Oscillator word is signed two's complement
// - New frequency applies on restart toggle or sync
// - Optional 6 dB gain in complex mode
// - Optional 3 dB gain in real mode
package ddc_pkg;
    localparam int ADC_W = 18;
    localparam int INT_W = 20;
    localparam int ACC_W = 25;
    localparam int NCO_W = 32;
    localparam int LUT_W = 10;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_NCO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_NCO_ACT = 8'h0C;
    localparam int B_EN = 0;
    localparam int B_REAL = 1;
    localparam int B_SWAP = 2;
    localparam int B_GAIN6 = 3;
    localparam int B_GAIN3 = 4;
    localparam int B_RESTART = 5;
    localparam int B_INV = 6;
    localparam int F_DEC_LO = 8;
    localparam int F_RES_LO = 12;
    localparam int S_EN = 0;
    localparam int S_PEND = 1;
    localparam logic [31:0] CTRL_RST = 32'h0000_2100;
    localparam logic [31:0] CTRL_MASK = 32'h0000_377F;
    localparam logic [NCO_W-1:0] NCO_RST = 32'h0000_0000;
    localparam logic [2:0] DEC_MIN = 3'h1;
    localparam logic [2:0] DEC_MAX = 3'h5;
    localparam logic [INT_W-1:0] MASK_14 = 20'hFFFC0;
    localparam logic [INT_W-1:0] MASK_16 = 20'hFFFF0;
    localparam logic [INT_W-1:0] MASK_18 = 20'hFFFFC;
    localparam logic [INT_W-1:0] MASK_20 = 20'hFFFFF;

    function automatic logic [INT_W-1:0] res_mask(logic [1:0] r);
        case (r)
            2'h0: return MASK_14;
            2'h1: return MASK_16;
            2'h2: return MASK_18;
            default: return MASK_20;
        endcase
    endfunction

    // Sixteen-step cosine, full scale 511
    function automatic logic signed [LUT_W-1:0] cos_lut(logic [3:0] k);
        logic signed [LUT_W-1:0] v;
        case (k[2:0])
            3'h0: v = 10'h1FF;
            3'h1: v = 10'h1D8;
            3'h2: v = 10'h169;
            3'h3: v = 10'h0C4;
            3'h4: v = 10'h000;
            3'h5: v = 10'h33C;
            3'h6: v = 10'h297;
            default: v = 10'h228;
        endcase
        return k[3] ? -v : v;
    endfunction
endpackage

// ---- include/ddc_ch_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface ddc_ch_if import ddc_pkg::*; ();
    logic en;
    logic real_mode;
    logic gain6;
    logic gain3;
    logic [2:0] dec_log2;
    logic signed [ADC_W-1:0] sample;
    logic signed [LUT_W-1:0] cos_v;
    logic signed [LUT_W-1:0] sin_v;
    logic signed [INT_W-1:0] out_i;
    logic signed [INT_W-1:0] out_q;
    logic out_vld;
    modport src (output en, real_mode, gain6, gain3, dec_log2, sample, cos_v, sin_v,
                 input out_i, out_q, out_vld);
    modport chan (input en, real_mode, gain6, gain3, dec_log2, sample, cos_v, sin_v,
                  output out_i, out_q, out_vld);
endinterface
`default_nettype wire

// ---- src/ddc_chan.sv ----
`timescale 1ns/100ps
`default_nettype none
module ddc_chan import ddc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Configuration, samples and results
    ddc_ch_if.chan ch
);
    localparam logic signed [INT_W-1:0] ZERO = 20'h00000;
    logic signed [ADC_W+LUT_W-1:0] prod_i;
    logic signed [ADC_W+LUT_W-1:0] prod_q;
    logic signed [INT_W-1:0] wide_s;
    logic signed [INT_W-1:0] mix_i;
    logic signed [INT_W-1:0] mix_q;
    logic signed [ACC_W-1:0] sum_i;
    logic signed [ACC_W-1:0] sum_q;
    logic signed [ACC_W-1:0] acc_i_reg;
    logic signed [ACC_W-1:0] acc_q_reg;
    logic signed [INT_W-1:0] avg_i;
    logic signed [INT_W-1:0] avg_q;
    logic signed [INT_W-1:0] out_i_reg;
    logic signed [INT_W-1:0] out_q_reg;
    logic signed [INT_W-1:0] out_i_next;
    logic signed [INT_W-1:0] out_q_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [4:0] last_cnt;
    logic [2:0] dec_eff;
    logic dump;
    logic vld_reg;
    logic vld_next;

    // Saturating gain: doubling, or about 1.41 from shifted adds
    function automatic logic signed [INT_W-1:0] apply_gain(logic signed [INT_W-1:0] x,
                                                           logic g6, logic g3);
        logic signed [INT_W+1:0] y;
        y = (INT_W+2)'(x);
        if (g6)
            y = y <<< 1;
        if (g3)
            y = y + (y >>> 2) + (y >>> 3) + (y >>> 5);
        if (y[INT_W+1:INT_W-1] == 3'h0 || y[INT_W+1:INT_W-1] == 3'h7)
            return y[INT_W-1:0];
        return y[INT_W+1] ? {1'b1, {(INT_W-1){1'b0}}} : {1'b0, {(INT_W-1){1'b1}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // decimation ratio
    assign dec_eff = ch.dec_log2 < DEC_MIN ? DEC_MIN :
                     (ch.dec_log2 > DEC_MAX ? DEC_MAX : ch.dec_log2);
    assign last_cnt = 5'((6'h01 << dec_eff) - 6'h01);
    assign dump = cnt_reg >= last_cnt;
    assign wide_s = {ch.sample, 2'h0};
    assign prod_i = ch.sample * ch.cos_v;
    assign prod_q = ch.sample * ch.sin_v;
    assign mix_i = ch.real_mode ? wide_s : prod_i[26:7];
    assign mix_q = ch.real_mode ? ZERO : prod_q[26:7];
    assign sum_i = acc_i_reg + ACC_W'(mix_i);
    assign sum_q = acc_q_reg + ACC_W'(mix_q);
    assign avg_i = INT_W'(sum_i >>> dec_eff);
    assign avg_q = INT_W'(sum_q >>> dec_eff);

    always_comb begin
        out_i_next = out_i_reg;
        out_q_next = out_q_reg;
        vld_next = 1'b0;
        cnt_next = cnt_reg + 5'h01;
        if (!ch.en) begin
            out_i_next = wide_s;
            out_q_next = ZERO;
            vld_next = 1'b1;
            cnt_next = 5'h00;
        end else if (dump) begin
            out_i_next = apply_gain(avg_i, ch.gain6 && !ch.real_mode, ch.gain3 && ch.real_mode);
            out_q_next = apply_gain(avg_q, ch.gain6 && !ch.real_mode, ch.gain3 && ch.real_mode);
            vld_next = 1'b1;
            cnt_next = 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || !ch.en || dump) begin
            acc_i_reg <= '0;
            acc_q_reg <= '0;
        end else begin
            acc_i_reg <= sum_i;
            acc_q_reg <= sum_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg <= 5'h00;
            vld_reg <= 1'b0;
            out_i_reg <= ZERO;
            out_q_reg <= ZERO;
        end else begin
            cnt_reg <= cnt_next;
            vld_reg <= vld_next;
            out_i_reg <= out_i_next;
            out_q_reg <= out_q_next;
        end
    end

    assign ch.out_i = out_i_reg;
    assign ch.out_q = out_q_reg;
    assign ch.out_vld = vld_reg;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_bypass;
        !ch.en |=> ch.out_vld && ch.out_i == {$past(ch.sample), 2'h0} && ch.out_q == ZERO;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass word missing");

    property p_real;
        ch.en && ch.real_mode |-> mix_q == ZERO && mix_i == wide_s;
    endproperty
    a_real: assert property (p_real) else $error("real mode still mixing");

    property p_dec2;
        (ch.en && dec_eff == 3'h1)[*3] |-> ch.out_vld != $past(ch.out_vld);
    endproperty
    a_dec2: assert property (p_dec2) else $error("decimate by two rate wrong");

    property p_gain6;
        ch.en && !ch.real_mode && ch.gain6 && dump && (avg_i[19:18] == 2'h0 || avg_i[19:18] == 2'h3)
            |=> ch.out_i == ($past(avg_i) <<< 1);
    endproperty
    a_gain6: assert property (p_gain6) else $error("6 dB gain wrong");

    c_dump: cover property (ch.en && !ch.real_mode && dump);
    c_real_dump: cover property (ch.en && ch.real_mode && ch.gain3 && dump);
endmodule // ddc_chan
`default_nettype wire

// ---- tb/ddc_fmt_model.sv ----
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////
// Formatter stand-in: takes each result set and measures pulse spacing
module ddc_fmt_model import ddc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Result stream
    input wire logic [INT_W-1:0] first_i,
    input wire logic [INT_W-1:0] first_q,
    input wire logic [INT_W-1:0] second_i,
    input wire logic [INT_W-1:0] second_q,
    input wire logic valid
);
    logic [INT_W-1:0] a_i, a_q, b_i, b_q;
    logic [4*INT_W-1:0] word;
    logic [4*INT_W-1:0] last;
    int count, gap, since, hold_err;

    assign word = {first_i, first_q, second_i, second_q};

    // Words must stand still between pulses
    always @(posedge clk) begin
        last <= word;
        if (!rst_b) begin
            count <= 0;
            since <= 0;
            gap <= 0;
            hold_err <= 0;
        end else if (valid) begin
            {a_i, a_q, b_i, b_q} <= word;
            count <= count + 1;
            gap <= since;
            since <= 1;
        end else begin
            since <= since + 1;
            if (word !== last) begin
                hold_err <= hold_err + 1;
            end
        end
    end
endmodule // ddc_fmt_model
`default_nettype wire

// ---- tb/dual_channel_ddc_with_input_swap_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dual_channel_ddc_with_input_swap_tb import ddc_pkg::*;;
    logic clk, rst_b, psel, penable, pwrite, sync, pready, pslverr, rerr, out_valid;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [ADC_W-1:0] adc_a, adc_b;
    logic [INT_W-1:0] f_i, f_q, s_i, s_q;
    int num_errors = 0;
    int num_checks = 0;
    localparam logic [ADC_W-1:0] VA = 18'h2ABCD;
    localparam logic [ADC_W-1:0] VB = 18'h15673;

    ddc_top i_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ADC_FIRST(adc_a), .ADC_SECOND(adc_b), .SYNC(sync), .FIRST_I(f_i), .FIRST_Q(f_q),
        .SECOND_I(s_i), .SECOND_Q(s_q), .OUT_VALID(out_valid));
    ddc_fmt_model m (.clk(clk), .rst_b(rst_b), .first_i(f_i), .first_q(f_q),
        .second_i(s_i), .second_q(s_q), .valid(out_valid));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////
    function automatic logic [INT_W-1:0] trunc(input logic [ADC_W-1:0] s, input int r);
        return {s, 2'b00} & (20'hFFFFF << (6 - 2 * r));
    endfunction

    function automatic logic [31:0] cw(input logic [6:0] b, input logic [2:0] d,
                                       input logic [1:0] r);
        return 32'(b) | (32'(d) << F_DEC_LO) | (32'(r) << F_RES_LO);
    endfunction

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) num_errors++;
        @(posedge clk);
    endtask

    task automatic wait_pulses(input int n);
        int c0, k;
        c0 = m.count;
        k = 0;
        while (m.count < c0 + n && k < 400) begin
            @(posedge clk);
            k++;
        end
        `CHK(m.count >= c0 + n, 1'b1);
    endtask

    ////////////////////////////////////////
    // Reset values and refused accesses
    task automatic t_regs();
        apb(1'b0, OFS_CTRL, 32'h0, rdat, rerr);
        `CHK(rdat, CTRL_RST);
        apb(1'b0, OFS_NCO, 32'h0, rdat, rerr);
        `CHK(rdat, 32'(NCO_RST));
        apb(1'b0, OFS_STAT, 32'h0, rdat, rerr);
        `CHK(rdat, 32'h0);
        apb(1'b0, 8'h10, 32'h0, rdat, rerr);
        `CHK({rerr, rdat}, {1'b1, 32'h0});
        apb(1'b1, OFS_STAT, 32'h3, rdat, rerr);
        `CHK(rerr, 1'b1);
        apb(1'b1, OFS_CTRL, 32'hFFFF_C880, rdat, rerr);
        apb(1'b0, OFS_CTRL, 32'h0, rdat, rerr);
        `CHK(rdat, 32'h0);
    endtask

    // Disabled converter passes every sample, truncated per resolution
    task automatic t_pass();
        adc_a <= VA;
        adc_b <= VB;
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, OFS_CTRL, cw(7'h00, 3'h1, 2'(r)), rdat, rerr);
            wait_pulses(4);
            `CHK(m.a_i, trunc(VA, r));
            `CHK({m.b_i, m.a_q}, {trunc(VB, r), 20'h0});
            `CHK(m.gap, 1);
        end
    endtask

    // Real mode with the oscillator word still zero, swap off then on
    task automatic t_swap();
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, OFS_CTRL, cw(s ? 7'h07 : 7'h03, 3'h1, 2'h3), rdat, rerr);
            wait_pulses(4);
            `CHK(m.a_i, trunc(s ? VB : VA, 3));
            `CHK(m.b_i, trunc(s ? VA : VB, 3));
            `CHK(m.b_q, 20'h00000);
            `CHK(m.gap, 2);
        end
    endtask

    // Gains act only in their own mode
    task automatic t_gain();
        logic [INT_W-1:0] g0;
        adc_a <= 18'h00100;
        apb(1'b1, OFS_CTRL, cw(7'h0B, 3'h1, 2'h3), rdat, rerr);
        wait_pulses(4);
        `CHK(m.a_i, 20'h00400);
        apb(1'b1, OFS_CTRL, cw(7'h13, 3'h1, 2'h3), rdat, rerr);
        wait_pulses(4);
        `CHK(m.a_i, 20'h005A0);
        apb(1'b1, OFS_CTRL, cw(7'h11, 3'h1, 2'h3), rdat, rerr);
        wait_pulses(4);
        g0 = m.a_i;
        apb(1'b1, OFS_CTRL, cw(7'h09, 3'h1, 2'h3), rdat, rerr);
        wait_pulses(4);
        `CHK(m.a_i, g0 << 1);
        `CHK(g0, 20'h003FE);
    endtask

    // Complex decimation spacing, clamped codes included
    task automatic t_dec();
        logic [2:0] code [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
        int gap [7] = '{2, 2, 4, 8, 16, 32, 32};
        for (int k = 0; k < 7; k++) begin
            apb(1'b1, OFS_CTRL, cw(7'h01, code[k], 2'h3), rdat, rerr);
            wait_pulses(4);
            `CHK(m.gap, gap[k]);
        end
    endtask

    // Oscillator word waits for restart toggle or sync
    task automatic t_nco();
        apb(1'b1, OFS_NCO, 32'h8000_0000, rdat, rerr);
        apb(1'b0, OFS_NCO_ACT, 32'h0, rdat, rerr);
        `CHK(rdat, 32'h0);
        apb(1'b0, OFS_STAT, 32'h0, rdat, rerr);
        `CHK(rdat[1:0], 2'b11);
        apb(1'b1, OFS_NCO_ACT, 32'h1, rdat, rerr);
        `CHK(rerr, 1'b1);
        apb(1'b1, OFS_CTRL, cw(7'h21, 3'h1, 2'h3), rdat, rerr);
        repeat (3) @(posedge clk);
        apb(1'b0, OFS_NCO_ACT, 32'h0, rdat, rerr);
        `CHK(rdat, 32'h8000_0000);
        apb(1'b0, OFS_STAT, 32'h0, rdat, rerr);
        `CHK(rdat[1:0], 2'b01);
        apb(1'b1, OFS_NCO, 32'h7FFF_FFFF, rdat, rerr);
        sync <= 1'b1;
        repeat (2) @(posedge clk);
        sync <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b0, OFS_NCO_ACT, 32'h0, rdat, rerr);
        `CHK(rdat, 32'h7FFF_FFFF);
    endtask

    // Quarter-turn oscillator applied by restart going low, then inverted phase
    task automatic t_inv();
        logic rel;
        apb(1'b1, OFS_NCO, 32'h4000_0000, rdat, rerr);
        apb(1'b1, OFS_CTRL, cw(7'h01, 3'h1, 2'h3), rdat, rerr);
        apb(1'b0, OFS_NCO_ACT, 32'h0, rdat, rerr);
        `CHK(rdat, 32'h4000_0000);
        wait_pulses(4);
        `CHK(m.a_i == 20'h001FF || m.a_i == 20'hFFE01, 1'b1);
        `CHK(m.a_q == m.a_i || m.a_q == 20'(-m.a_i), 1'b1);
        rel = m.a_q == m.a_i;
        apb(1'b1, OFS_CTRL, cw(7'h41, 3'h1, 2'h3), rdat, rerr);
        wait_pulses(4);
        `CHK(m.a_q, rel ? 20'(-m.a_i) : m.a_i);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100us;
        num_errors++;
        print_verdict();
    end

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        sync = 1'b0;
        adc_a = '0;
        adc_b = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_pass();
        t_swap();
        t_gain();
        t_dec();
        t_nco();
        t_inv();
        `CHK(m.hold_err, 0);
        print_verdict();
    end
endmodule // dual_channel_ddc_with_input_swap_tb
`default_nettype wire
